// file: core/phy_cfg_pkg.sv
// Constants shared by the strap, indicator and reset control logic
package phy_cfg_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam int unsigned ADDR_W = 14;
	localparam logic [11:0] IDX_BASIC_MODE_CONTROL = 12'h000;
	localparam logic [11:0] IDX_INDICATOR_CONFIG_ONE = 12'h018;
	localparam logic [11:0] IDX_GLOBAL_CONTROL = 12'h01F;
	localparam logic [11:0] IDX_STRAP_STATUS = 12'h020;
	localparam logic [11:0] IDX_FIBER_CONTROL = 12'hC00;
	localparam logic [11:0] FIBER_BLOCK_BASE = 12'hC00;
	localparam logic [11:0] FIBER_BLOCK_MASK = 12'h0FF;

	// Field positions
	localparam int unsigned BIT_SOFT_RESET = 15;
	localparam int unsigned BIT_GLOBAL_RESET = 15;
	localparam int unsigned BIT_GLOBAL_RESTART = 14;
	localparam int unsigned BIT_STS_IEEE_BUSY = 15;
	localparam int unsigned BIT_STS_GLOBAL_BUSY = 14;
	localparam int unsigned BIT_STS_RESTART_BUSY = 13;
	localparam int unsigned BIT_STS_VALID = 12;
	localparam int unsigned BIT_STS_LINK_LOSS = 8;
	localparam int unsigned IND_FIELD_W = 4;

	// Reset values
	localparam logic [15:0] BMC_RST_VAL = 16'h1140;
	localparam logic [15:0] FIBER_CTRL_RST_VAL = 16'h1140;
	localparam logic [15:0] GLOBAL_CTRL_RST_VAL = 16'h0000;

	// Operating mode strap codes
	localparam logic [2:0] MODE_RGMII_COPPER = 3'h0;
	localparam logic [2:0] MODE_RGMII_1000X = 3'h1;
	localparam logic [2:0] MODE_RGMII_100FX = 3'h2;
	localparam logic [2:0] MODE_RGMII_SGMII = 3'h3;
	localparam logic [2:0] MODE_MC_1000 = 3'h4;
	localparam logic [2:0] MODE_MC_100 = 3'h5;
	localparam logic [2:0] MODE_SGMII_COPPER = 3'h6;
	localparam logic [2:0] MODE_SGMII_RGMII = 3'h7;

	// Indicator function codes, one nibble per indicator
	localparam logic [3:0] IND_LINK = 4'h0;
	localparam logic [3:0] IND_ACT = 4'h1;
	localparam logic [3:0] IND_TX = 4'h2;
	localparam logic [3:0] IND_RX = 4'h3;
	localparam logic [3:0] IND_LINK_ACT = 4'h4;
	localparam logic [3:0] IND_ON = 4'h5;
	localparam logic [3:0] IND_OFF = 4'h6;
	localparam logic [3:0] IND_FIBER_LINK = 4'h7;

	// Default indicator configuration per mode group
	localparam logic [15:0] IND_CFG_DEF_COPPER = 16'h0140;
	localparam logic [15:0] IND_CFG_DEF_CONVERT = 16'h0170;
	localparam logic [15:0] IND_CFG_DEF_BRIDGE = 16'h0610;

	// Copper link speed codes
	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned SOFT_RESET_NS = 1000;
	localparam int unsigned SOFT_RESET_CYC =
		(SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STRAP_SETTLE_CYC = 4;
endpackage

// file: core/strap_capture.sv
// Strap synchroniser, latch and auto-negotiation decode
`timescale 1ns/1ps
module strap_capture #(
	parameter int unsigned SETTLE_CYC = phy_cfg_pkg::STRAP_SETTLE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [2:0] i_mode_pin,
	input wire logic [2:0] i_ind_pin,
	input wire logic i_loss_pin,
	output logic [2:0] o_mode,
	output logic [2:0] o_ind,
	output logic o_loss,
	output logic o_valid,
	output logic o_advert_1000,
	output logic o_advert_100,
	output logic o_advert_10,
	output logic o_auto_mdix,
	output logic o_downshift_en,
	output logic o_copper_aneg_en,
	output logic o_fiber_aneg_en
);
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic [3:0] settle_r;
	logic [6:0] adv;

	// Decode {1000,100,10,mdix,downshift,copper aneg,fiber aneg}
	function automatic logic [6:0] decode(input logic [2:0] m,
		input logic [2:0] s);
		logic [1:0] sel;
		logic fx;
		sel = {s[2], s[1]};
		fx = ~s[0];
		decode = 7'h00;
		case (m)
			phy_cfg_pkg::MODE_MC_1000: begin
				if (sel == 2'h0)
					decode = 7'h6A | {6'h00, fx};
				else
					decode = {6'h00, fx};
			end
			phy_cfg_pkg::MODE_MC_100: begin
				if (sel == 2'h0)
					decode = 7'h3A;
				else if (sel == 2'h3)
					decode = 7'h2A;
			end
			phy_cfg_pkg::MODE_RGMII_COPPER,
			phy_cfg_pkg::MODE_SGMII_COPPER: begin
				case ({s[0], sel})
					3'h0: decode = 7'h7E;
					3'h1: decode = 7'h6E;
					3'h2: decode = 7'h3E;
					default: decode = 7'h00;
				endcase
			end
			phy_cfg_pkg::MODE_RGMII_1000X,
			phy_cfg_pkg::MODE_RGMII_100FX: decode = {6'h00, fx};
			default: decode = 7'h00;
		endcase
	endfunction

	// Two-flop synchroniser on all strap pins
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
		end else begin
			sync1_r <= {i_loss_pin, i_ind_pin, i_mode_pin};
			sync2_r <= sync1_r;
		end
	end

	// Settle count after reset release before the one-time latch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			settle_r <= 4'h0;
		else if (!o_valid)
			settle_r <= settle_r + 4'h1;
	end

	assign adv = decode(sync2_r[2:0], sync2_r[5:3]);

	// Latch straps once per hardware reset; nothing else clears them
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
			o_mode <= 3'h0;
			o_ind <= 3'h0;
			o_loss <= 1'b0;
			{o_advert_1000, o_advert_100, o_advert_10, o_auto_mdix,
				o_downshift_en, o_copper_aneg_en, o_fiber_aneg_en} <= 7'h00;
		end else if (!o_valid && settle_r == SETTLE_CYC[3:0]) begin
			o_valid <= 1'b1;
			o_mode <= sync2_r[2:0];
			o_ind <= sync2_r[5:3];
			o_loss <= sync2_r[6];
			{o_advert_1000, o_advert_100, o_advert_10, o_auto_mdix,
				o_downshift_en, o_copper_aneg_en, o_fiber_aneg_en} <= adv;
		end
	end

	AST_MC1000_ADVERT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_valid && o_mode == phy_cfg_pkg::MODE_MC_1000 && o_ind[2:1] == 2'h0
		|-> o_advert_1000 && o_advert_100 && !o_advert_10 && o_auto_mdix)
		else $error("gigabit converter advert wrong");
	AST_MC1000_NO_DOWNSHIFT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_valid && o_mode == phy_cfg_pkg::MODE_MC_1000 |-> !o_downshift_en)
		else $error("gigabit converter may downshift");
	AST_STRAP_HELD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_valid |=> o_valid && $stable(o_mode) && $stable(o_ind))
		else $error("latched strap changed");
endmodule // strap_capture

// file: core/phy_strap_led_reset_control.sv
// Strap, indicator and reset control with APB register access
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// What this block does
// - Gigabit converter with selects 00 advertises 1000/100 with auto crossover
// - Link-loss strap low enables loss passthrough in the converter modes, high disables it
// - Gigabit converter never downshifts copper to 100 Mb/s
// - Three indicators with defaults chosen by the latched mode strap
// - Indicator functions are selected by indicator_config_one at 18h
// - Indicator active-high if its strap read low, active-low if high
// - Forced-speed RGMII-to-SGMII bridge offers no link indication
// - Bridge modes show activity, tx or rx only, from the RGMII side
// - Gigabit converter link indicator shows only a 1000 Mb/s copper link
// - 100 Mb/s converter link indicator shows only a 100 Mb/s copper link
// - Hardware reset restores all registers and re-samples straps
// - Bit 15 of basic_mode_control resets only the IEEE registers
// - Global bit 15 resets circuits and registers, keeps latched straps
// - Global bit 14 restarts circuits but keeps register contents
// - In fiber modes the fiber block appears at the low addresses
module phy_strap_led_reset_control #(
	parameter int unsigned RESET_CYC = phy_cfg_pkg::SOFT_RESET_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [phy_cfg_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [2:0] i_operating_mode_strap,
	input wire logic i_link_loss_strap,
	input wire logic [2:0] i_indicator_pin_in,
	output logic [2:0] o_indicator_pin_out,
	output logic [2:0] o_indicator_pin_oe,
	input wire logic i_link_up,
	input wire logic [1:0] i_link_speed,
	input wire logic i_fiber_link,
	input wire logic i_tx_act,
	input wire logic i_rx_act,
	input wire logic i_rgmii_tx_act,
	input wire logic i_rgmii_rx_act,
	output logic o_advert_1000,
	output logic o_advert_100,
	output logic o_advert_10,
	output logic o_auto_mdix,
	output logic o_downshift_en,
	output logic o_copper_aneg_en,
	output logic o_fiber_aneg_en,
	output logic o_link_loss_pass_en,
	output logic o_ieee_reset,
	output logic o_core_reset,
	output logic o_core_restart,
	output logic o_strap_valid
);
	typedef enum logic [1:0] {ST_IDLE, ST_IEEE, ST_GLOBAL, ST_RESTART} act_t;

	localparam int RST_MAX = 40;

	act_t state_r;
	logic [7:0] cnt_r;
	logic [15:0] basic_mode_control_r;
	logic [15:0] fiber_control_r;
	logic [15:0] indicator_config_one_r;
	logic [15:0] global_control_r;
	logic [2:0] mode;
	logic [2:0] ind_strap;
	logic loss_strap;
	logic strap_seen_r;
	logic load_def;
	logic fiber_mode;
	logic bridge_mode;
	logic busy;
	logic [11:0] idx;
	logic [11:0] eff_idx;
	logic addr_ok;
	logic setup;
	logic wr;
	logic [15:0] wdat;
	logic [15:0] rd_val;
	logic rd_hit;
	logic link_sig;
	logic tx_sig;
	logic rx_sig;
	logic [2:0] ind_active;

	strap_capture u_strap (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_mode_pin(i_operating_mode_strap),
		.i_ind_pin(i_indicator_pin_in),
		.i_loss_pin(i_link_loss_strap),
		.o_mode(mode),
		.o_ind(ind_strap),
		.o_loss(loss_strap),
		.o_valid(o_strap_valid),
		.o_advert_1000(o_advert_1000),
		.o_advert_100(o_advert_100),
		.o_advert_10(o_advert_10),
		.o_auto_mdix(o_auto_mdix),
		.o_downshift_en(o_downshift_en),
		.o_copper_aneg_en(o_copper_aneg_en),
		.o_fiber_aneg_en(o_fiber_aneg_en)
	);

	// Default indicator layout for the latched operating mode
	function automatic logic [15:0] ind_default(input logic [2:0] m);
		case (m)
			phy_cfg_pkg::MODE_MC_1000,
			phy_cfg_pkg::MODE_MC_100,
			phy_cfg_pkg::MODE_RGMII_1000X,
			phy_cfg_pkg::MODE_RGMII_100FX:
				ind_default = phy_cfg_pkg::IND_CFG_DEF_CONVERT;
			phy_cfg_pkg::MODE_RGMII_SGMII,
			phy_cfg_pkg::MODE_SGMII_RGMII:
				ind_default = phy_cfg_pkg::IND_CFG_DEF_BRIDGE;
			default: ind_default = phy_cfg_pkg::IND_CFG_DEF_COPPER;
		endcase
	endfunction

	// Evaluate one indicator function code
	function automatic logic ind_eval(input logic [3:0] f, input logic lk,
		input logic tx, input logic rx, input logic fl);
		case (f)
			phy_cfg_pkg::IND_LINK: ind_eval = lk;
			phy_cfg_pkg::IND_ACT: ind_eval = tx | rx;
			phy_cfg_pkg::IND_TX: ind_eval = tx;
			phy_cfg_pkg::IND_RX: ind_eval = rx;
			phy_cfg_pkg::IND_LINK_ACT: ind_eval = lk & ~(tx | rx);
			phy_cfg_pkg::IND_ON: ind_eval = 1'b1;
			phy_cfg_pkg::IND_FIBER_LINK: ind_eval = fl;
			default: ind_eval = 1'b0;
		endcase
	endfunction

	// Mode groups from the latched strap
	assign fiber_mode = (mode == phy_cfg_pkg::MODE_RGMII_1000X) ||
		(mode == phy_cfg_pkg::MODE_RGMII_100FX);
	assign bridge_mode = (mode == phy_cfg_pkg::MODE_RGMII_SGMII) ||
		(mode == phy_cfg_pkg::MODE_SGMII_RGMII);
	assign busy = (state_r != ST_IDLE);

	// Loss passthrough only in the converter modes, low strap enables it
	assign o_link_loss_pass_en = !loss_strap &&
		((mode == phy_cfg_pkg::MODE_MC_1000) ||
		(mode == phy_cfg_pkg::MODE_MC_100));

	// APB decode; fiber block folds onto the low addresses
	assign idx = i_paddr[phy_cfg_pkg::ADDR_W-1:2];
	assign addr_ok = (i_paddr[1:0] == 2'h0);
	assign eff_idx = (fiber_mode && idx[11:8] == 4'h0 &&
		((idx | phy_cfg_pkg::FIBER_BLOCK_BASE) ==
		phy_cfg_pkg::IDX_FIBER_CONTROL)) ?
		(idx | phy_cfg_pkg::FIBER_BLOCK_BASE) : idx;
	assign setup = i_psel && !i_penable;
	assign o_pready = i_psel && i_penable;
	assign wr = i_psel && i_penable && i_pwrite && addr_ok && !busy;
	assign wdat = i_pwdata[15:0];

	// Read mux; self-clearing bits read back as the action in progress
	always_comb begin
		rd_val = 16'h0000;
		rd_hit = addr_ok;
		case (eff_idx)
			phy_cfg_pkg::IDX_BASIC_MODE_CONTROL: begin
				rd_val = basic_mode_control_r;
				rd_val[phy_cfg_pkg::BIT_SOFT_RESET] = (state_r == ST_IEEE);
			end
			phy_cfg_pkg::IDX_FIBER_CONTROL: begin
				rd_val = fiber_control_r;
				rd_val[phy_cfg_pkg::BIT_SOFT_RESET] = (state_r == ST_IEEE);
			end
			phy_cfg_pkg::IDX_INDICATOR_CONFIG_ONE:
				rd_val = indicator_config_one_r;
			phy_cfg_pkg::IDX_GLOBAL_CONTROL: begin
				rd_val = global_control_r;
				rd_val[phy_cfg_pkg::BIT_GLOBAL_RESET] = (state_r == ST_GLOBAL);
				rd_val[phy_cfg_pkg::BIT_GLOBAL_RESTART] =
					(state_r == ST_RESTART);
			end
			phy_cfg_pkg::IDX_STRAP_STATUS: begin
				rd_val[2:0] = mode;
				rd_val[6:4] = ind_strap;
				rd_val[phy_cfg_pkg::BIT_STS_LINK_LOSS] = loss_strap;
				rd_val[phy_cfg_pkg::BIT_STS_VALID] = o_strap_valid;
				rd_val[phy_cfg_pkg::BIT_STS_RESTART_BUSY] = (state_r == ST_RESTART);
				rd_val[phy_cfg_pkg::BIT_STS_GLOBAL_BUSY] = (state_r == ST_GLOBAL);
				rd_val[phy_cfg_pkg::BIT_STS_IEEE_BUSY] = (state_r == ST_IEEE);
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// Read data and error are captured in the setup cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (setup) begin
			o_prdata <= (rd_hit && !i_pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
			o_pslverr <= !rd_hit;
		end
	end

	// Reset/restart sequencer; global reset wins over restart
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 8'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (wr && eff_idx == phy_cfg_pkg::IDX_GLOBAL_CONTROL &&
						wdat[phy_cfg_pkg::BIT_GLOBAL_RESET]) begin
						state_r <= ST_GLOBAL;
						cnt_r <= RESET_CYC[7:0];
					end else if (wr && eff_idx == phy_cfg_pkg::IDX_GLOBAL_CONTROL &&
						wdat[phy_cfg_pkg::BIT_GLOBAL_RESTART]) begin
						state_r <= ST_RESTART;
						cnt_r <= RESET_CYC[7:0];
					end else if (wr && wdat[phy_cfg_pkg::BIT_SOFT_RESET] &&
						(eff_idx == phy_cfg_pkg::IDX_BASIC_MODE_CONTROL ||
						eff_idx == phy_cfg_pkg::IDX_FIBER_CONTROL)) begin
						state_r <= ST_IEEE;
						cnt_r <= RESET_CYC[7:0];
					end
				end
				ST_IEEE, ST_GLOBAL, ST_RESTART: begin
					if (cnt_r == 8'h01)
						state_r <= ST_IDLE;
					cnt_r <= cnt_r - 8'h01;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Reset strobes to the rest of the device
	assign o_ieee_reset = (state_r == ST_IEEE);
	assign o_core_reset = (state_r == ST_GLOBAL);
	assign o_core_restart = (state_r == ST_RESTART);

	// Indicator defaults load once the straps are first latched
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			strap_seen_r <= 1'b0;
		else if (o_strap_valid)
			strap_seen_r <= 1'b1;
	end
	assign load_def = o_strap_valid && !strap_seen_r;

	// IEEE registers: hardware, IEEE and global resets restore defaults
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			basic_mode_control_r <= phy_cfg_pkg::BMC_RST_VAL;
			fiber_control_r <= phy_cfg_pkg::FIBER_CTRL_RST_VAL;
		end else if (state_r == ST_IEEE || state_r == ST_GLOBAL) begin
			basic_mode_control_r <= phy_cfg_pkg::BMC_RST_VAL;
			fiber_control_r <= phy_cfg_pkg::FIBER_CTRL_RST_VAL;
		end else if (wr && !wdat[phy_cfg_pkg::BIT_SOFT_RESET]) begin
			if (eff_idx == phy_cfg_pkg::IDX_BASIC_MODE_CONTROL)
				basic_mode_control_r <= wdat;
			if (eff_idx == phy_cfg_pkg::IDX_FIBER_CONTROL)
				fiber_control_r <= wdat;
		end
	end

	// Extended registers: only hardware and global resets restore them
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			indicator_config_one_r <= phy_cfg_pkg::IND_CFG_DEF_COPPER;
			global_control_r <= phy_cfg_pkg::GLOBAL_CTRL_RST_VAL;
		end else if (load_def || state_r == ST_GLOBAL) begin
			indicator_config_one_r <= ind_default(mode);
			global_control_r <= phy_cfg_pkg::GLOBAL_CTRL_RST_VAL;
		end else if (wr) begin
			if (eff_idx == phy_cfg_pkg::IDX_INDICATOR_CONFIG_ONE)
				indicator_config_one_r <= wdat;
			if (eff_idx == phy_cfg_pkg::IDX_GLOBAL_CONTROL &&
				!wdat[phy_cfg_pkg::BIT_GLOBAL_RESET] &&
				!wdat[phy_cfg_pkg::BIT_GLOBAL_RESTART])
				global_control_r <= wdat;
		end
	end

	// Link source per mode; forced bridge gives none
	always_comb begin
		case (mode)
			phy_cfg_pkg::MODE_MC_1000:
				link_sig = i_link_up && i_link_speed == phy_cfg_pkg::SPEED_1000;
			phy_cfg_pkg::MODE_MC_100:
				link_sig = i_link_up && i_link_speed == phy_cfg_pkg::SPEED_100;
			phy_cfg_pkg::MODE_RGMII_SGMII:
				link_sig = i_link_up && o_copper_aneg_en;
			phy_cfg_pkg::MODE_RGMII_1000X,
			phy_cfg_pkg::MODE_RGMII_100FX: link_sig = i_fiber_link;
			default: link_sig = i_link_up;
		endcase
	end

	// Bridges report activity seen on the RGMII side
	assign tx_sig = bridge_mode ? i_rgmii_tx_act : i_tx_act;
	assign rx_sig = bridge_mode ? i_rgmii_rx_act : i_rx_act;

	// Per-indicator function from its nibble of indicator_config_one
	always_comb begin
		for (int i = 0; i < 3; i++)
			ind_active[i] = ind_eval(indicator_config_one_r[i*4 +: 4],
				link_sig, tx_sig, rx_sig, i_fiber_link);
	end

	// Pin drive: polarity from the strap, released until straps latch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_indicator_pin_out <= 3'h0;
			o_indicator_pin_oe <= 3'h0;
		end else begin
			o_indicator_pin_oe <= {3{o_strap_valid}};
			if (busy && state_r != ST_IEEE)
				o_indicator_pin_out <= ind_strap; // Dark during global reset and restart
			else
				o_indicator_pin_out <= ind_active ^ ind_strap;
		end
	end

	AST_POLARITY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_strap_valid && !busy && $past(o_strap_valid) && !$past(busy)
		|=> o_indicator_pin_out == ($past(ind_active) ^ ind_strap))
		else $error("indicator polarity wrong");
	AST_BRIDGE_FORCED_NO_LINK: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		mode == phy_cfg_pkg::MODE_RGMII_SGMII && !o_copper_aneg_en |-> !link_sig)
		else $error("forced bridge shows link");
	AST_BRIDGE_RGMII_ACT: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		bridge_mode |-> tx_sig == i_rgmii_tx_act && rx_sig == i_rgmii_rx_act)
		else $error("bridge activity not from RGMII");
	AST_MC1000_LINK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		mode == phy_cfg_pkg::MODE_MC_1000 && i_link_speed != phy_cfg_pkg::SPEED_1000
		|-> !link_sig)
		else $error("gigabit converter link at wrong speed");
	AST_MC100_LINK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		mode == phy_cfg_pkg::MODE_MC_100 && i_link_speed != phy_cfg_pkg::SPEED_100
		|-> !link_sig)
		else $error("100M converter link at wrong speed");
	AST_IEEE_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_ieee_reset) |-> basic_mode_control_r == $past(basic_mode_control_r)
		##1 basic_mode_control_r == phy_cfg_pkg::BMC_RST_VAL &&
		$stable(indicator_config_one_r))
		else $error("IEEE reset touched wrong registers");
	AST_GLOBAL_KEEPS_STRAP: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		o_core_reset |=> $stable(mode) && $stable(ind_strap) &&
		global_control_r == phy_cfg_pkg::GLOBAL_CTRL_RST_VAL)
		else $error("global reset lost straps or registers");
	AST_RESTART_KEEPS_REGS: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		o_core_restart |=> $stable(indicator_config_one_r) &&
		$stable(basic_mode_control_r))
		else $error("restart altered register file");
	AST_SELF_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(busy) |-> ##[1:RST_MAX] !busy)
		else $error("reset action never ends");
	AST_FIBER_MAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		fiber_mode && idx == phy_cfg_pkg::IDX_BASIC_MODE_CONTROL
		|-> eff_idx == phy_cfg_pkg::IDX_FIBER_CONTROL)
		else $error("fiber block not folded");
endmodule // phy_strap_led_reset_control

// file: tb/host_model.sv
// Host controller model: hardware reset pin and APB master
`timescale 1ns/1ps
module host_model (
	input wire logic i_clk,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	input wire logic i_pslverr,
	output logic o_rst_n,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [phy_cfg_pkg::ADDR_W-1:0] o_paddr,
	output logic [31:0] o_pwdata
);
	// Reset held and bus idle from time zero
	initial begin
		o_rst_n = 1'b0;
		{o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
	end
	// Low pulse on the reset pin, n clock cycles long
	task pulse_reset(input int n);
		o_rst_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_rst_n <= 1'b1;
	endtask
	// One transfer, held until pready is sampled high
	task xfer(input logic w, input logic [11:0] idx, input logic [15:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= w;
		o_paddr <= {idx, 2'b00};
		o_pwdata <= {16'h0000, d};
		@(posedge i_clk);
		o_penable <= 1'b1;
		@(posedge i_clk);
		while (i_pready !== 1'b1) @(posedge i_clk);
		rd = i_prdata;
		err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
	endtask
endmodule // host_model

// file: tb/test_phy_strap_led_reset_control.sv
// Self-checking bench for strap, indicator and reset control
`timescale 1ns/1ps
module test_phy_strap_led_reset_control;
	logic clk, rst_n, psel, pen, pwr, pready, perr, lup, fib, pass_en, sv;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rdv, x;
	logic [2:0] mode_s, ind_s, pin_in, pin_out, pin_oe, rs;
	logic [1:0] spd;
	logic [6:0] adv;
	logic [3:0] act;
	logic [15:0] v;
	logic loss_s, erv;
	int error_cnt, samples_checked;
	// Indicator pads: pad drives when enabled, else the strap resistor wins
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ind_s);
	phy_strap_led_reset_control i_phy_strap_led_reset_control (
		.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
		.i_operating_mode_strap(mode_s), .i_link_loss_strap(loss_s),
		.i_indicator_pin_in(pin_in), .o_indicator_pin_out(pin_out),
		.o_indicator_pin_oe(pin_oe), .i_link_up(lup), .i_link_speed(spd),
		.i_fiber_link(fib), .i_tx_act(act[0]), .i_rx_act(act[1]),
		.i_rgmii_tx_act(act[2]), .i_rgmii_rx_act(act[3]),
		.o_advert_1000(adv[6]), .o_advert_100(adv[5]), .o_advert_10(adv[4]),
		.o_auto_mdix(adv[3]), .o_downshift_en(adv[2]),
		.o_copper_aneg_en(adv[1]), .o_fiber_aneg_en(adv[0]),
		.o_link_loss_pass_en(pass_en), .o_ieee_reset(rs[0]),
		.o_core_reset(rs[1]), .o_core_restart(rs[2]), .o_strap_valid(sv));
	host_model i_host (.i_clk(clk), .i_pready(pready), .i_prdata(prdata),
		.i_pslverr(perr), .o_rst_n(rst_n), .o_psel(psel), .o_penable(pen),
		.o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));
	// Clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Fixed-seed xorshift source
	function automatic logic [31:0] xs();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	// Expected strap status word
	function automatic logic [31:0] sts();
		return {19'h0, 1'b1, 3'h0, loss_s, 1'b0, ind_s, 1'b0, mode_s};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		i_host.xfer(1'b1, a, d, rdv, erv);
	endtask
	task rd(input logic [11:0] a);
		i_host.xfer(1'b0, a, 16'h0000, rdv, erv);
	endtask
	// Poll until a self-clearing bit reads 0, bounded; s is the strobe seen
	task wait_clear(input logic [11:0] a, input int b, input logic [2:0] s);
		rd(a);
		chk(rs, s);
		for (int i = 0; i < 100 && rdv[b] !== 1'b0; i++) rd(a);
		chk(rdv[b], 1'b0);
		chk(rs, 3'h0);
	endtask
	// Hardware reset with new strap levels, then wait for the latch
	task hw_reset(input logic [2:0] m, input logic [3:0] sl);
		mode_s <= m;
		{ind_s, loss_s} <= sl;
		@(posedge clk);
		i_host.pulse_reset(25);
		repeat (10) @(posedge clk);
	endtask
	// Indicator pads at the 1000 and 100 Mb/s link speeds; m4 picks the expected active pattern
	task ind_chk(input logic m4);
		for (int i = 0; i < 2; i++) begin
			spd <= i ? phy_cfg_pkg::SPEED_100 : phy_cfg_pkg::SPEED_1000;
			act <= 4'(xs());
			repeat (3) @(posedge clk);
			if (m4) chk(pin_out, {i == 0, 2'b01} ^ ind_s);
			else chk(pin_out, {|act[1:0], 1'b0, i == 1} ^ ind_s);
			chk(pin_oe, 3'h7);
		end
	endtask
	task tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		{error_cnt, samples_checked, fib, act} = '0;
		x = 32'd97;
		mode_s = phy_cfg_pkg::MODE_MC_1000;
		{ind_s, loss_s, lup, spd} = {3'b000, 1'b0, 1'b1, 2'h2};
		i_host.pulse_reset(20);
		repeat (10) @(posedge clk);
		chk(adv, 7'b1101011);
		chk(sv, 1'b1);
		chk(pass_en, 1'b1);
		rd(phy_cfg_pkg::IDX_BASIC_MODE_CONTROL);
		chk(rdv, phy_cfg_pkg::BMC_RST_VAL);
		rd(phy_cfg_pkg::IDX_INDICATOR_CONFIG_ONE);
		chk(rdv, phy_cfg_pkg::IND_CFG_DEF_CONVERT);
		rd(12'h005);
		chk(rdv, 32'h0);
		chk(erv, 1'b1);
		$display("test straps done");
		wr(phy_cfg_pkg::IDX_INDICATOR_CONFIG_ONE, 16'h0065);
		ind_chk(1'b1);
		$display("test indicators done");
		v = 16'(xs()) & 16'h3FFF;
		wr(phy_cfg_pkg::IDX_GLOBAL_CONTROL, v);
		wr(phy_cfg_pkg::IDX_GLOBAL_CONTROL, v | 16'h4000);
		wait_clear(phy_cfg_pkg::IDX_GLOBAL_CONTROL, 14, 3'b100);
		chk(rdv, v);
		wr(phy_cfg_pkg::IDX_BASIC_MODE_CONTROL, 16'h0100);
		wr(phy_cfg_pkg::IDX_BASIC_MODE_CONTROL, 16'h8000);
		wait_clear(phy_cfg_pkg::IDX_BASIC_MODE_CONTROL, 15, 3'b001);
		chk(rdv, phy_cfg_pkg::BMC_RST_VAL);
		rd(phy_cfg_pkg::IDX_INDICATOR_CONFIG_ONE);
		chk(rdv, 32'h65);
		wr(phy_cfg_pkg::IDX_GLOBAL_CONTROL, 16'h8000);
		wait_clear(phy_cfg_pkg::IDX_GLOBAL_CONTROL, 15, 3'b010);
		chk(rdv, phy_cfg_pkg::GLOBAL_CTRL_RST_VAL);
		rd(phy_cfg_pkg::IDX_INDICATOR_CONFIG_ONE);
		chk(rdv, phy_cfg_pkg::IND_CFG_DEF_CONVERT);
		rd(phy_cfg_pkg::IDX_STRAP_STATUS);
		chk(rdv, sts());
		$display("test software resets done");
		hw_reset(phy_cfg_pkg::MODE_MC_100, 4'b1101);
		rd(phy_cfg_pkg::IDX_STRAP_STATUS);
		chk(rdv, sts());
		chk(pass_en, 1'b0);
		ind_chk(1'b0);
		$display("test hardware reset done");
		hw_reset(phy_cfg_pkg::MODE_RGMII_1000X, 4'b0000);
		v = 16'(xs()) & 16'h7FFF;
		wr(phy_cfg_pkg::IDX_BASIC_MODE_CONTROL, v);
		rd(phy_cfg_pkg::IDX_FIBER_CONTROL);
		chk(rdv, v);
		$display("test fiber map done");
		hw_reset(phy_cfg_pkg::MODE_RGMII_SGMII, 4'b0010);
		for (int i = 0; i < 4; i++) begin
			act <= 4'(xs());
			repeat (3) @(posedge clk);
			chk(pin_out, {1'b0, |act[3:2], 1'b0} ^ ind_s);
		end
		$display("test bridge done");
		tally_and_finish();
	end
endmodule // test_phy_strap_led_reset_control
